// File: hdl/twst_pkg.sv
package twst_pkg;
	localparam int REG_AW = 3;
	localparam logic [2:0] OFF_CTRL = 3'h0;
	localparam logic [2:0] OFF_STAT = 3'h1;
	localparam logic [2:0] OFF_DATA = 3'h2;
	localparam logic [2:0] OFF_ADDR = 3'h3;
	localparam logic [2:0] OFF_IRQ_ST = 3'h4;
	localparam logic [2:0] OFF_IRQ_MASK = 3'h5;
	localparam int CTRL_DONE = 7;
	localparam int CTRL_ACK = 6;
	localparam int CTRL_STA = 5;
	localparam int CTRL_STO = 4;
	localparam int CTRL_EN = 2;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_BERR = 1;
	localparam int IRQ_WAKE = 2;
	localparam logic [7:0] ST_OWN_READ = 8'ha8;
	localparam logic [7:0] ST_ARB_READ = 8'hb0;
	localparam logic [7:0] ST_DATA_ACK = 8'hb8;
	localparam logic [7:0] ST_DATA_NACK = 8'hc0;
	localparam logic [7:0] ST_LAST_ACK = 8'hc8;
	localparam logic [7:0] ST_NONE = 8'hf8;
	localparam logic [7:0] ST_BUS_ERR = 8'h00;
	localparam logic [7:0] STAT_CODE_MASK = 8'hf8;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_BIT_IDX = 4'h7;
	localparam logic [7:0] OWN_ADDR_RST = 8'h00;
	typedef enum logic [2:0] {
		TWST_IDLE,
		TWST_ADDR,
		TWST_ACKA,
		TWST_TX,
		TWST_TACK,
		TWST_HOLD,
		TWST_GONE,
		TWST_BERR
	} twst_state_t;
endpackage : twst_pkg

// File: hdl/twst_slave_tx.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module twst_slave_tx (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Register port
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// Two-wire pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	// Power and master-side hooks
	input wire logic sleep_in,
	input wire logic arb_lost_in,
	output logic wake_out,
	output logic start_go_out,
	// Interrupt
	output logic irq_out
);
	typedef struct packed {
		twst_pkg::twst_state_t state;
		logic done;
		logic ack_en;
		logic sta;
		logic sto;
		logic en;
		logic [1:0] presc;
		logic [7:0] code;
		logic [7:0] data;
		logic [7:0] own;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic last;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic scl_f;
		logic sda_f;
		logic sda_oe_n;
		logic scl_oe_n;
		logic [2:0] irq_st;
		logic [2:0] irq_mask;
		logic irq;
		logic [7:0] rdata;
		logic wake;
		logic start_pend;
		logic bus_free;
		logic start_go;
	} twst_regs_t;

	twst_regs_t r_reg;
	twst_regs_t r_next;

	logic scl_rise, scl_fall, bus_start, bus_stop, mid_frame, addr_match, sw_clear;
	logic [2:0] ev;
	logic [7:0] stat_view;

	always_comb begin
		r_next = r_reg;
		ev = 3'h0;
		// Third stage trails the second; a level counts once both agree
		r_next.scl_s = {r_reg.scl_s[1:0], scl_in};
		r_next.sda_s = {r_reg.sda_s[1:0], sda_in};
		if (r_reg.scl_s[1] == r_reg.scl_s[2]) begin
			r_next.scl_f = r_reg.scl_s[2];
		end
		if (r_reg.sda_s[1] == r_reg.sda_s[2]) begin
			r_next.sda_f = r_reg.sda_s[2];
		end
		scl_rise = !r_reg.scl_f && r_next.scl_f;
		scl_fall = r_reg.scl_f && !r_next.scl_f;
		bus_start = r_reg.scl_f && r_next.scl_f && r_reg.sda_f && !r_next.sda_f;
		bus_stop = r_reg.scl_f && r_next.scl_f && !r_reg.sda_f && r_next.sda_f;
		mid_frame = (r_reg.state == twst_pkg::TWST_ADDR && r_reg.cnt != 4'h0)
			|| r_reg.state == twst_pkg::TWST_ACKA || r_reg.state == twst_pkg::TWST_TX
			|| (r_reg.state == twst_pkg::TWST_TACK && !r_reg.scl_f);
		// Address bit 0 is the direction; only reads are served here
		addr_match = r_reg.ack_en && r_reg.en && r_reg.sh[0]
			&& (r_reg.sh[7:1] == r_reg.own[7:1] || (r_reg.sh[7:1] == 7'h00 && r_reg.own[0]));
		sw_clear = reg_wr_in && reg_addr_in == twst_pkg::OFF_CTRL && reg_wdata_in[twst_pkg::CTRL_DONE];
		stat_view = r_reg.done ? (r_reg.code & twst_pkg::STAT_CODE_MASK) : twst_pkg::ST_NONE;

		// Software side of the register port
		if (reg_wr_in) begin
			case (reg_addr_in)
				twst_pkg::OFF_CTRL: begin
					r_next.ack_en = reg_wdata_in[twst_pkg::CTRL_ACK];
					r_next.sta = reg_wdata_in[twst_pkg::CTRL_STA];
					r_next.sto = reg_wdata_in[twst_pkg::CTRL_STO];
					r_next.en = reg_wdata_in[twst_pkg::CTRL_EN];
					if (sw_clear) begin
						r_next.done = 1'b0;
					end
				end
				twst_pkg::OFF_STAT: r_next.presc = reg_wdata_in[1:0];
				twst_pkg::OFF_DATA: r_next.data = reg_wdata_in;
				twst_pkg::OFF_ADDR: r_next.own = reg_wdata_in;
				twst_pkg::OFF_IRQ_MASK: r_next.irq_mask = reg_wdata_in[2:0];
				default: ;
			endcase
		end
		r_next.rdata = 8'h00;
		if (reg_rd_in) begin
			case (reg_addr_in)
				twst_pkg::OFF_CTRL: r_next.rdata = {r_reg.done, r_reg.ack_en, r_reg.sta, r_reg.sto,
					1'b0, r_reg.en, 2'h0};
				twst_pkg::OFF_STAT: r_next.rdata = {stat_view[7:3], 1'b0, r_reg.presc};
				twst_pkg::OFF_DATA: r_next.rdata = r_reg.data;
				twst_pkg::OFF_ADDR: r_next.rdata = r_reg.own;
				twst_pkg::OFF_IRQ_ST: r_next.rdata = {5'h00, r_reg.irq_st};
				twst_pkg::OFF_IRQ_MASK: r_next.rdata = {5'h00, r_reg.irq_mask};
				default: r_next.rdata = 8'h00;
			endcase
		end

		// Queued START waits for a free bus, then is handed to master logic
		r_next.start_go = 1'b0;
		if (bus_start) begin
			r_next.bus_free = 1'b0;
		end else if (bus_stop) begin
			r_next.bus_free = 1'b1;
		end
		if (r_reg.start_pend && r_reg.bus_free) begin
			r_next.start_go = 1'b1;
			r_next.start_pend = 1'b0;
		end

		// Bus protocol; in HOLD and GONE new control takes effect only on the done clear
		case (r_reg.state)
			twst_pkg::TWST_IDLE: ;
			twst_pkg::TWST_ADDR: begin
				if (scl_rise && r_reg.cnt != twst_pkg::BITS_PER_BYTE) begin
					r_next.sh = {r_reg.sh[6:0], r_reg.sda_f};
					r_next.cnt = r_reg.cnt + 4'h1;
				end else if (scl_fall && r_reg.cnt == twst_pkg::BITS_PER_BYTE) begin
					if (addr_match) begin
						r_next.state = twst_pkg::TWST_ACKA;
						if (sleep_in) begin
							r_next.wake = 1'b1;
							ev[twst_pkg::IRQ_WAKE] = 1'b1;
						end
					end else begin
						r_next.state = twst_pkg::TWST_IDLE;
					end
				end
			end
			twst_pkg::TWST_ACKA: begin
				if (scl_fall) begin
					r_next.state = twst_pkg::TWST_HOLD;
					r_next.code = arb_lost_in ? twst_pkg::ST_ARB_READ : twst_pkg::ST_OWN_READ;
					ev[twst_pkg::IRQ_DONE] = 1'b1;
				end
			end
			twst_pkg::TWST_HOLD: begin
				// After a B8 the clear may come while SCL is still high; wait for low so SDA never moves then
				if (!r_reg.done && !r_reg.scl_f) begin
					// Buffer content is whatever software last wrote, not bus history
					r_next.sh = r_reg.data;
					r_next.last = !r_reg.ack_en;
					r_next.cnt = 4'h0;
					r_next.wake = 1'b0;
					r_next.state = twst_pkg::TWST_TX;
				end
			end
			twst_pkg::TWST_TX: begin
				if (scl_fall) begin
					if (r_reg.cnt == twst_pkg::LAST_BIT_IDX) begin
						r_next.state = twst_pkg::TWST_TACK;
					end else begin
						r_next.sh = {r_reg.sh[6:0], 1'b1};
						r_next.cnt = r_reg.cnt + 4'h1;
					end
				end
			end
			twst_pkg::TWST_TACK: begin
				if (scl_rise) begin
					ev[twst_pkg::IRQ_DONE] = 1'b1;
					if (r_reg.sda_f) begin
						r_next.code = twst_pkg::ST_DATA_NACK;
						r_next.state = twst_pkg::TWST_GONE;
					end else if (r_reg.last) begin
						r_next.code = twst_pkg::ST_LAST_ACK;
						r_next.state = twst_pkg::TWST_GONE;
					end else begin
						r_next.code = twst_pkg::ST_DATA_ACK;
						r_next.state = twst_pkg::TWST_HOLD;
					end
				end
			end
			twst_pkg::TWST_GONE: begin
				// Further master clocks are ignored and SDA stays released
				if (!r_reg.done) begin
					r_next.state = twst_pkg::TWST_IDLE;
					r_next.start_pend = r_reg.sta;
				end
			end
			twst_pkg::TWST_BERR: begin
				if (sw_clear && reg_wdata_in[twst_pkg::CTRL_STO]) begin
					r_next.state = twst_pkg::TWST_IDLE;
					r_next.sto = 1'b0;
				end
			end
			default: r_next.state = twst_pkg::TWST_IDLE;
		endcase

		// Framing conditions override the byte machine
		if ((bus_start || bus_stop) && mid_frame) begin
			r_next.state = twst_pkg::TWST_BERR;
			r_next.code = twst_pkg::ST_BUS_ERR;
			ev[twst_pkg::IRQ_BERR] = 1'b1;
			ev[twst_pkg::IRQ_DONE] = 1'b1;
		end else if (bus_start && r_reg.state != twst_pkg::TWST_HOLD && r_reg.state != twst_pkg::TWST_BERR) begin
			r_next.state = twst_pkg::TWST_ADDR;
			r_next.cnt = 4'h0;
		end else if (bus_stop && (r_reg.state == twst_pkg::TWST_ADDR || r_reg.state == twst_pkg::TWST_TACK)) begin
			r_next.state = twst_pkg::TWST_IDLE;
		end

		// Hardware set wins over a clear in the same cycle
		if (ev[twst_pkg::IRQ_DONE]) begin
			r_next.done = 1'b1;
		end
		if (reg_wr_in && reg_addr_in == twst_pkg::OFF_IRQ_ST) begin
			r_next.irq_st = r_reg.irq_st & ~reg_wdata_in[2:0];
		end
		r_next.irq_st = r_next.irq_st | ev;
		r_next.irq = |(r_next.irq_st & r_next.irq_mask);

		// Pin drive from the next state so the pins come straight from flops
		r_next.sda_oe_n = !(r_next.state == twst_pkg::TWST_ACKA
			|| (r_next.state == twst_pkg::TWST_TX && !r_next.sh[7]));
		// Only pull SCL once the master has let it fall, never mid-high
		r_next.scl_oe_n = !(r_next.state == twst_pkg::TWST_HOLD && r_next.done && !r_next.scl_f);
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			r_reg <= '0;
			r_reg.state <= twst_pkg::TWST_IDLE;
			r_reg.own <= twst_pkg::OWN_ADDR_RST;
			r_reg.scl_s <= 3'h7;
			r_reg.sda_s <= 3'h7;
			r_reg.scl_f <= 1'b1;
			r_reg.sda_f <= 1'b1;
			r_reg.sda_oe_n <= 1'b1;
			r_reg.scl_oe_n <= 1'b1;
			r_reg.bus_free <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign reg_rdata_out = r_reg.rdata;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n_out = r_reg.scl_oe_n;
	assign sda_oe_n_out = r_reg.sda_oe_n;
	assign wake_out = r_reg.wake;
	assign start_go_out = r_reg.start_go;
	assign irq_out = r_reg.irq;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	status_idle_a: assert property (reg_rd_in && reg_addr_in == twst_pkg::OFF_STAT && !r_reg.done
		|=> reg_rdata_out[7:3] == twst_pkg::ST_NONE[7:3]) else $error("status not idle code");
	scl_hold_a: assert property (r_reg.state == twst_pkg::TWST_HOLD && r_reg.done && !r_reg.scl_f
		&& !sw_clear |=> !scl_oe_n_out) else $error("scl not held");
	bus_err_a: assert property ((bus_start || bus_stop) && mid_frame
		|=> r_reg.done && r_reg.code == twst_pkg::ST_BUS_ERR) else $error("bus error missed");
	berr_exit_a: assert property (r_reg.state == twst_pkg::TWST_BERR && sw_clear
		&& reg_wdata_in[twst_pkg::CTRL_STO] |=> r_reg.state == twst_pkg::TWST_IDLE && !r_reg.sto
		&& r_reg.ack_en == $past(reg_wdata_in[twst_pkg::CTRL_ACK]) ##1 sda_oe_n_out && scl_oe_n_out)
		else $error("bad error recovery");
	sda_change_a: assert property (r_reg.state == twst_pkg::TWST_TX && $changed(sda_oe_n_out)
		|-> !r_reg.scl_f) else $error("sda moved with scl high");
	code_ack_a: assert property (r_reg.state == twst_pkg::TWST_TACK && scl_rise && !r_reg.sda_f
		&& !r_reg.last && !bus_stop |=> r_reg.code == twst_pkg::ST_DATA_ACK && r_reg.done) else $error("no b8");
	code_nack_a: assert property (r_reg.state == twst_pkg::TWST_TACK && scl_rise && r_reg.sda_f
		|=> r_reg.code == twst_pkg::ST_DATA_NACK && r_reg.state == twst_pkg::TWST_GONE) else $error("no c0");
	code_last_a: assert property (r_reg.state == twst_pkg::TWST_TACK && scl_rise && !r_reg.sda_f
		&& r_reg.last |=> r_reg.code == twst_pkg::ST_LAST_ACK) else $error("no c8");
	addr_ignore_a: assert property (r_reg.state == twst_pkg::TWST_ADDR && !r_reg.ack_en
		&& scl_fall && r_reg.cnt == twst_pkg::BITS_PER_BYTE && !bus_start && !bus_stop
		|=> r_reg.state == twst_pkg::TWST_IDLE) else $error("address not ignored");
	sleep_wake_a: assert property (r_reg.state == twst_pkg::TWST_ADDR && scl_fall && addr_match
		&& sleep_in && r_reg.cnt == twst_pkg::BITS_PER_BYTE |=> wake_out ##1 !sda_oe_n_out) else $error("no wake");
	gone_quiet_a: assert property (r_reg.state == twst_pkg::TWST_GONE |-> sda_oe_n_out)
		else $error("sda driven after last byte");

	b8_seen_c: cover property (r_reg.done && r_reg.code == twst_pkg::ST_DATA_ACK);
	c0_seen_c: cover property (r_reg.done && r_reg.code == twst_pkg::ST_DATA_NACK);
	berr_seen_c: cover property (r_reg.state == twst_pkg::TWST_BERR ##1 r_reg.state == twst_pkg::TWST_IDLE);
	wake_seen_c: cover property ($rose(wake_out));
endmodule : twst_slave_tx

// File: testbench/twst_master_model.sv
`timescale 1ns/10ps
module twst_master_model (
	// Clock
	input wire logic mclk_in,
	// Bus wires
	input wire logic scl_in,
	input wire logic sda_in,
	// Line drives, high releases to the pull-up
	output logic scl_out,
	output logic sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic hp();
		repeat (10) @(posedge mclk_in);
	endtask : hp
	task automatic pulse(output logic b);
		int k;
		hp();
		scl_out <= 1'b1;
		// The slave may stretch the low phase
		for (k = 0; k < 3000 && scl_in !== 1'b1; k++) @(posedge mclk_in);
		hp();
		b = sda_in;
		scl_out <= 1'b0;
	endtask : pulse
	task automatic wbit(input logic v);
		logic x;
		@(posedge mclk_in);
		sda_out <= v;
		pulse(x);
	endtask : wbit
	task automatic rbit(output logic b);
		@(posedge mclk_in);
		sda_out <= 1'b1;
		pulse(b);
	endtask : rbit
	task automatic wbyte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) wbit(d[i]);
	endtask : wbyte
	task automatic rbyte(output logic [7:0] d);
		for (int i = 7; i >= 0; i--) rbit(d[i]);
	endtask : rbyte
	task automatic start_cond();
		@(posedge mclk_in);
		sda_out <= 1'b1;
		hp();
		scl_out <= 1'b1;
		hp();
		sda_out <= 1'b0;
		hp();
		scl_out <= 1'b0;
	endtask : start_cond
	task automatic stop_cond();
		@(posedge mclk_in);
		sda_out <= 1'b0;
		hp();
		scl_out <= 1'b1;
		hp();
		sda_out <= 1'b1;
		hp();
	endtask : stop_cond
endmodule : twst_master_model

// File: testbench/two_wire_slave_transmit_status_bench.sv
`timescale 1ns/10ps
module two_wire_slave_transmit_status_bench;
	logic mclk_in, rst_in, reg_wr, reg_rd, sleep_in, arb_lost_in, go_seen, b;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, s;
	logic scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda, wake_out, start_go_out, irq_out;
	wire logic scl_w = m_scl & (scl_oe_n | scl_o);
	wire logic sda_w = m_sda & (sda_oe_n | sda_o);
	int errors = 0;
	int n_tests = 0;
	int seed = 32'hfd47;
	logic [7:0] sent_q[$];
	twst_slave_tx DUT (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .scl_in(scl_w), .scl_out(scl_o),
		.scl_oe_n_out(scl_oe_n), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .sleep_in(sleep_in),
		.arb_lost_in(arb_lost_in), .wake_out(wake_out), .start_go_out(start_go_out), .irq_out(irq_out));
	twst_master_model PM (.mclk_in(mclk_in), .scl_in(scl_w), .sda_in(sda_w), .scl_out(m_scl), .sda_out(m_sda));
	initial begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) if (start_go_out === 1'b1) go_seen <= 1'b1;
	task automatic summarize();
		if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk_in);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk_in);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic wait_done();
		logic [7:0] c;
		c = 8'h00;
		for (int k = 0; k < 400 && c[7] !== 1'b1; k++) rd(twst_pkg::OFF_CTRL, c);
		chk("done", {7'h0, c[7]}, 8'h01);
	endtask : wait_done
	task automatic probe(input logic [7:0] ab);
		PM.start_cond();
		PM.wbyte(ab);
		PM.rbit(b);
		chk("refused ack", {7'h0, b}, 8'h01);
		PM.stop_cond();
	endtask : probe
	task automatic session(input logic [6:0] a, input int n, input logic mack, input logic [7:0] c0,
		input logic sta);
		logic [7:0] d, r;
		PM.start_cond();
		PM.wbyte({a, 1'b1});
		PM.rbit(b);
		chk("addr ack", {7'h0, b}, 8'h00);
		wait_done();
		rd(twst_pkg::OFF_STAT, r);
		chk("status", r & twst_pkg::STAT_CODE_MASK, c0);
		chk("wake", {7'h0, wake_out}, {7'h0, sleep_in});
		chk("scl hold", {7'h0, scl_oe_n}, 8'h00);
		chk("irq", {7'h0, irq_out}, 8'h01);
		wr(twst_pkg::OFF_IRQ_ST, 8'h07);
		@(posedge mclk_in);
		#1 chk("irq clr", {7'h0, irq_out}, 8'h00);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			sent_q.push_back(d);
			wr(twst_pkg::OFF_DATA, d);
			wr(twst_pkg::OFF_CTRL, (i == n - 1) ? 8'h84 : 8'hc4);
			PM.rbyte(r);
			chk("byte", r, sent_q.pop_front());
			PM.wbit((i == n - 1) ? ~mack : 1'b0);
			wait_done();
			rd(twst_pkg::OFF_STAT, r);
			chk("status", r & twst_pkg::STAT_CODE_MASK, (i < n - 1) ? twst_pkg::ST_DATA_ACK :
				(mack ? twst_pkg::ST_LAST_ACK : twst_pkg::ST_DATA_NACK));
		end
		wr(twst_pkg::OFF_CTRL, {2'b11, sta, 5'h04});
		if (mack) begin
			PM.rbyte(r);
			chk("after last", r, 8'hff);
		end
		PM.stop_cond();
	endtask : session
	initial begin
		rst_in = 1'b1;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sleep_in = 1'b0;
		arb_lost_in = 1'b0;
		go_seen = 1'b0;
		repeat (5) @(posedge mclk_in);
		rst_in <= 1'b0;
		rd(twst_pkg::OFF_CTRL, s);
		chk("ctrl rst", s, 8'h00);
		rd(twst_pkg::OFF_STAT, s);
		chk("status idle", s, twst_pkg::ST_NONE);
		rd(twst_pkg::OFF_ADDR, s);
		chk("addr rst", s, twst_pkg::OWN_ADDR_RST);
		rd(3'h6, s);
		chk("unmapped", s, 8'h00);
		wr(twst_pkg::OFF_ADDR, 8'h54);
		wr(twst_pkg::OFF_IRQ_MASK, 8'h01);
		wr(twst_pkg::OFF_CTRL, 8'h04);
		probe(8'h55);
		wr(twst_pkg::OFF_CTRL, 8'h44);
		probe(8'h57);
		probe(8'h54);
		probe(8'h01);
		session(7'h2a, 3, 1'b0, twst_pkg::ST_OWN_READ, 1'b1);
		repeat (20) @(posedge mclk_in);
		chk("start queued", {7'h0, go_seen}, 8'h01);
		session(7'h2a, 2, 1'b1, twst_pkg::ST_OWN_READ, 1'b0);
		arb_lost_in <= 1'b1;
		session(7'h2a, 1, 1'b0, twst_pkg::ST_ARB_READ, 1'b0);
		arb_lost_in <= 1'b0;
		sleep_in <= 1'b1;
		session(7'h2a, 1, 1'b0, twst_pkg::ST_OWN_READ, 1'b0);
		sleep_in <= 1'b0;
		wr(twst_pkg::OFF_ADDR, 8'h55);
		session(7'h00, 1, 1'b0, twst_pkg::ST_OWN_READ, 1'b0);
		// Mid-byte START while the slave sends ones
		PM.start_cond();
		PM.wbyte(8'h55);
		PM.rbit(b);
		wait_done();
		wr(twst_pkg::OFF_DATA, 8'hff);
		wr(twst_pkg::OFF_CTRL, 8'hc4);
		PM.rbit(b);
		PM.rbit(b);
		PM.start_cond();
		wait_done();
		rd(twst_pkg::OFF_STAT, s);
		chk("status berr", s & twst_pkg::STAT_CODE_MASK, twst_pkg::ST_BUS_ERR);
		rd(twst_pkg::OFF_IRQ_ST, s);
		chk("irq berr", s & 8'h02, 8'h02);
		wr(twst_pkg::OFF_CTRL, 8'hd4);
		rd(twst_pkg::OFF_CTRL, s);
		chk("ctrl recover", s, 8'h44);
		chk("lines free", {6'h0, scl_oe_n, sda_oe_n}, 8'h03);
		PM.stop_cond();
		summarize();
	end
	initial begin
		repeat (80000) @(posedge mclk_in);
		errors++;
		summarize();
	end
endmodule : two_wire_slave_transmit_status_bench
